// >>> verilog/stc_pkg.sv
// Shared constants and types of the two-channel stepper chopper control.
// Assumes a single 100 MHz clock and an AXI4-Lite register port.

package stc_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;          // 100 MHz system clock
  localparam int DIR_DELAY_NS  = 3000;        // Turn-on delay after a rising phase input
  localparam int BLANK_NS      = 2000;        // Comparator blanking after turn-on
  localparam int CARRIER_HZ    = 30000;       // Nominal carrier with reference capacitor
  localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
  // Least times round up to whole cycles
  localparam logic [8:0] DELAY_CYC = 9'((DIR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [8:0] BLANK_CYC = 9'((BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] CARRIER_CYC = 16'(CLK_HZ / CARRIER_HZ);
  localparam logic [15:0] CARRIER_MIN = 16'h0004;  // Shortest usable carrier period

  // ==========================================================================
  // Chopping levels (fractions of full scale, in 1/256)
  // ==========================================================================
  localparam logic [7:0] FRAC_70 = 8'hb3;     // 179/256, about 70 percent
  localparam logic [7:0] FRAC_30 = 8'h4d;     // 77/256, about 30 percent

  // ==========================================================================
  // Register map (byte addresses) and reset values
  // ==========================================================================
  localparam logic [11:0] REG_CTRL    = 12'h000;
  localparam logic [11:0] REG_FSCALE  = 12'h004;
  localparam logic [11:0] REG_PERIOD  = 12'h008;
  localparam logic [11:0] REG_STATUS  = 12'h00c;
  localparam int          CTRL_EN_BIT = 0;
  localparam logic        CTRL_RST    = 1'b1;
  localparam logic [7:0]  FSCALE_RST  = 8'h32;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic       dir_a;      // Phase direction A
    logic       dir_b;      // Phase direction B
    logic       sel_lo;     // Level select, low bit
    logic       sel_hi;     // Level select, high bit
    logic [7:0] sense;      // Digitised sense resistor voltage
  } stc_chan_in_t;

  typedef struct packed {
    logic a_lvl;            // Bridge A level when enabled
    logic a_en;             // Bridge A driven
    logic b_lvl;            // Bridge B level when enabled
    logic b_en;             // Bridge B driven
  } stc_chan_out_t;

  typedef struct packed {
    logic on;               // Bridge conducting
    logic chopped;          // Off after a trip, waiting for carrier
    logic trip;             // Comparator output
  } stc_chan_stat_t;

  typedef enum logic [2:0] {
    ST_OFF   = 3'b000,
    ST_DELAY = 3'b001,
    ST_BLANK = 3'b010,
    ST_ON    = 3'b011,
    ST_CHOP  = 3'b100
  } stc_state_t;

endpackage

// >>> verilog/stc_chan.sv
// One chopper channel: phase decode, level threshold, delay, blanking, chopping.
// Assumes inputs synchronous to clk and a one-cycle carrier start pulse.
`timescale 1ns/1ps
`default_nettype none

module stc_chan (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // Controls
  input  wire stc_pkg::stc_chan_in_t   chan_in,
  input  wire logic [7:0]              full_scale,
  input  wire logic                    carrier_start,
  input  wire logic                    enable,
  // Results
  output var  stc_pkg::stc_chan_out_t  chan_out,
  output var  stc_pkg::stc_chan_stat_t chan_stat
);
  import stc_pkg::*;

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic        drive_a;            // Current flows A to B
  logic        drive_b;            // Current flows B to A
  logic        zero_lvl;           // Both select bits high
  logic        drive_ok;           // Bridge may conduct
  logic        rise;               // A phase input went high
  logic [15:0] prod70;             // Scaled thresholds
  logic [15:0] prod30;
  logic [7:0]  threshold;          // Selected chopping level
  logic        trip;               // Comparator output
  logic [1:0]  dir_prev_r;         // Last phase inputs
  stc_state_t  state_r;
  stc_state_t  state_nxt;
  logic [8:0]  cnt_r;              // Delay and blanking counter
  logic [8:0]  cnt_nxt;
  logic        bridge_on;          // Next-cycle conduction

  assign drive_a  = chan_in.dir_a & ~chan_in.dir_b;
  assign drive_b  = ~chan_in.dir_a & chan_in.dir_b;
  assign zero_lvl = chan_in.sel_lo & chan_in.sel_hi;
  // Equal inputs give neither drive term, so the bridge goes off
  assign drive_ok = (drive_a | drive_b) & enable & ~zero_lvl;
  assign rise     = |({chan_in.dir_a, chan_in.dir_b} & ~dir_prev_r);
  assign prod70   = full_scale * FRAC_70;
  assign prod30   = full_scale * FRAC_30;
  // Select the chopping level from the two select bits
  assign threshold = chan_in.sel_hi ? prod30[15:8] :
                     chan_in.sel_lo ? prod70[15:8] : full_scale;
  assign trip      = chan_in.sense > threshold;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  // A new rising edge restarts the delay from any conducting state
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (!drive_ok) begin
      state_nxt = ST_OFF;
      cnt_nxt   = 9'h000;
    end else if (rise) begin
      state_nxt = ST_DELAY;
      cnt_nxt   = DELAY_CYC - 9'h001;
    end else begin
      case (state_r)
        ST_OFF: begin
          state_nxt = ST_BLANK;
          cnt_nxt   = BLANK_CYC - 9'h001;
        end
        ST_DELAY: begin
          if (cnt_r == 9'h000) begin
            state_nxt = ST_BLANK;
            cnt_nxt   = BLANK_CYC - 9'h001;
          end else begin
            cnt_nxt = cnt_r - 9'h001;
          end
        end
        ST_BLANK: begin
          // Comparator ignored while the turn-on spike settles
          if (cnt_r == 9'h000) begin
            state_nxt = ST_ON;
          end else begin
            cnt_nxt = cnt_r - 9'h001;
          end
        end
        ST_ON: begin
          if (trip) begin
            state_nxt = ST_CHOP;
          end
        end
        ST_CHOP: begin
          // Stay off until the next carrier period begins
          if (carrier_start) begin
            state_nxt = ST_BLANK;
            cnt_nxt   = BLANK_CYC - 9'h001;
          end
        end
        default: begin
          state_nxt = ST_OFF;
        end
      endcase
    end
  end

  assign bridge_on = (state_nxt == ST_BLANK) || (state_nxt == ST_ON);

  // State, counter and registered outputs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= ST_OFF;
      cnt_r      <= 9'h000;
      dir_prev_r <= 2'b00;
      chan_out   <= '0;
      chan_stat  <= '0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      dir_prev_r <= {chan_in.dir_a, chan_in.dir_b};
      chan_out   <= '{a_lvl: drive_a, a_en: bridge_on, b_lvl: drive_b, b_en: bridge_on};
      chan_stat  <= '{on: bridge_on, chopped: (state_nxt == ST_CHOP), trip: trip};
    end
  end

endmodule
`default_nettype wire

// >>> verilog/stc_top.sv
// Top of the two-channel stepper chopper control with AXI4-Lite registers.
// Assumes pins synchronous to clk; bridge enables drive the power stage.
//
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module stc_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Channel 1 pins
  input  wire logic        ch1_dir_a_in,
  input  wire logic        ch1_dir_b_in,
  input  wire logic        ch1_level_sel_low,
  input  wire logic        ch1_level_sel_high,
  input  wire logic [7:0]  ch1_sense_voltage,
  output logic             ch1_bridge_a_out,
  output logic             ch1_bridge_a_en,
  output logic             ch1_bridge_b_out,
  output logic             ch1_bridge_b_en,
  // Channel 2 pins
  input  wire logic        ch2_dir_a_in,
  input  wire logic        ch2_dir_b_in,
  input  wire logic        ch2_level_sel_low,
  input  wire logic        ch2_level_sel_high,
  input  wire logic [7:0]  ch2_sense_voltage,
  output logic             ch2_bridge_a_out,
  output logic             ch2_bridge_a_en,
  output logic             ch2_bridge_b_out,
  output logic             ch2_bridge_b_en,
  // Standby, low disables drive
  input  wire logic        standby_n,
  // AXI4-Lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import stc_pkg::*;

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic        ctrl_en_r;        // Software drive enable
  logic [7:0]  fscale_r;         // Full-scale threshold code
  logic [15:0] period_r;         // Carrier period in clock cycles

  // Write channel state
  logic        aw_held_r;        // Write address captured
  logic        w_held_r;         // Write data captured
  logic [11:0] waddr_r;          // Captured write address
  logic [31:0] wdata_r;          // Captured write data
  logic [3:0]  wstrb_r;          // Captured byte strobes
  logic        bvalid_r;         // Write response pending
  logic [1:0]  bresp_r;          // Write response code

  // Read channel state
  logic        rvalid_r;         // Read data pending
  logic [31:0] rdata_r;          // Read data
  logic [1:0]  rresp_r;          // Read response code

  // ==========================================================================
  // Carrier
  // ==========================================================================
  logic [15:0] car_cnt_r;        // Triangle position
  logic        car_up_r;         // Counting up
  logic [15:0] car_period;       // Clamped period
  logic [14:0] car_half;         // Peak of the triangle
  logic        carrier_start;    // One-cycle pulse at the valley

  // Too short a period would never reach its peak, so clamp it
  assign car_period    = (period_r < CARRIER_MIN) ? CARRIER_MIN : period_r;
  assign car_half      = car_period[15:1];
  assign carrier_start = ~car_up_r & (car_cnt_r == 16'h0000);

  // Up-down counter stands in for the capacitor ramp; period set by software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      car_cnt_r <= 16'h0000;
      car_up_r  <= 1'b1;
    end else if (car_up_r) begin
      if (car_cnt_r >= {1'b0, car_half} - 16'h0001) begin
        car_up_r <= 1'b0;
      end else begin
        car_cnt_r <= car_cnt_r + 16'h0001;
      end
    end else begin
      if (car_cnt_r == 16'h0000) begin
        car_up_r <= 1'b1;
      end else begin
        car_cnt_r <= car_cnt_r - 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Channels
  // ==========================================================================
  stc_chan_in_t   ch1_in;        // Channel 1 pin bundle
  stc_chan_in_t   ch2_in;        // Channel 2 pin bundle
  stc_chan_out_t  ch1_out;       // Channel 1 bridge drive
  stc_chan_out_t  ch2_out;       // Channel 2 bridge drive
  stc_chan_stat_t ch1_stat;      // Channel 1 status
  stc_chan_stat_t ch2_stat;      // Channel 2 status
  logic           drive_enable;  // Standby and software enable

  assign drive_enable = standby_n & ctrl_en_r;
  // Each channel gets only its own pins
  assign ch1_in = '{dir_a: ch1_dir_a_in, dir_b: ch1_dir_b_in,
                    sel_lo: ch1_level_sel_low, sel_hi: ch1_level_sel_high,
                    sense: ch1_sense_voltage};
  assign ch2_in = '{dir_a: ch2_dir_a_in, dir_b: ch2_dir_b_in,
                    sel_lo: ch2_level_sel_low, sel_hi: ch2_level_sel_high,
                    sense: ch2_sense_voltage};

  // Channel 1 chopper
  stc_chan u_ch1 (
    .clk           (clk),
    .reset_n       (reset_n),
    .chan_in       (ch1_in),
    .full_scale    (fscale_r),
    .carrier_start (carrier_start),
    .enable        (drive_enable),
    .chan_out      (ch1_out),
    .chan_stat     (ch1_stat)
  );

  // Channel 2 chopper
  stc_chan u_ch2 (
    .clk           (clk),
    .reset_n       (reset_n),
    .chan_in       (ch2_in),
    .full_scale    (fscale_r),
    .carrier_start (carrier_start),
    .enable        (drive_enable),
    .chan_out      (ch2_out),
    .chan_stat     (ch2_stat)
  );

  // Bridge pins come straight from channel flip-flops
  assign ch1_bridge_a_out = ch1_out.a_lvl;
  assign ch1_bridge_a_en  = ch1_out.a_en;
  assign ch1_bridge_b_out = ch1_out.b_lvl;
  assign ch1_bridge_b_en  = ch1_out.b_en;
  assign ch2_bridge_a_out = ch2_out.a_lvl;
  assign ch2_bridge_a_en  = ch2_out.a_en;
  assign ch2_bridge_b_out = ch2_out.b_lvl;
  assign ch2_bridge_b_en  = ch2_out.b_en;

  // ==========================================================================
  // AXI4-Lite write path
  // ==========================================================================
  logic        aw_take;          // Address handshake this cycle
  logic        w_take;           // Data handshake this cycle
  logic        wr_commit;        // Both halves present
  logic [11:0] wr_addr;          // Address for the commit
  logic [31:0] wr_data;          // Data for the commit
  logic [3:0]  wr_strb;          // Strobes for the commit
  logic        wr_ctrl;          // Decodes
  logic        wr_fscale;
  logic        wr_period;
  logic        wr_status;
  logic        wr_mapped;

  // Each half is taken once; a pending response blocks new ones
  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign wr_commit     = (aw_held_r | aw_take) & (w_held_r | w_take);
  assign wr_addr       = aw_held_r ? waddr_r : s_axi_awaddr;
  assign wr_data       = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_strb       = w_held_r ? wstrb_r : s_axi_wstrb;
  assign wr_ctrl       = wr_addr[11:2] == REG_CTRL[11:2];
  assign wr_fscale     = wr_addr[11:2] == REG_FSCALE[11:2];
  assign wr_period     = wr_addr[11:2] == REG_PERIOD[11:2];
  assign wr_status     = wr_addr[11:2] == REG_STATUS[11:2];
  assign wr_mapped     = wr_ctrl | wr_fscale | wr_period | wr_status;

  // Capture halves and answer once both are in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      waddr_r   <= 12'h000;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
    end else begin
      if (wr_commit) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held_r <= 1'b1;
          waddr_r   <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held_r <= 1'b1;
          wdata_r  <= s_axi_wdata;
          wstrb_r  <= s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
          bvalid_r <= 1'b0;
        end
      end
    end
  end

  // Register updates, byte lanes honoured; status is read-only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_en_r <= CTRL_RST;
      fscale_r  <= FSCALE_RST;
      period_r  <= CARRIER_CYC;
    end else if (wr_commit) begin
      if (wr_ctrl && wr_strb[0]) begin
        ctrl_en_r <= wr_data[CTRL_EN_BIT];
      end
      if (wr_fscale && wr_strb[0]) begin
        fscale_r <= wr_data[7:0];
      end
      if (wr_period && wr_strb[0]) begin
        period_r[7:0] <= wr_data[7:0];
      end
      if (wr_period && wr_strb[1]) begin
        period_r[15:8] <= wr_data[15:8];
      end
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp  = bresp_r;

  // ==========================================================================
  // AXI4-Lite read path
  // ==========================================================================
  logic        ar_take;          // Read address handshake
  logic [31:0] status_word;      // Live block state
  logic [31:0] rd_mux;           // Selected read data
  logic        rd_mapped;        // Address hits a register

  assign s_axi_arready = ~rvalid_r;
  assign ar_take       = s_axi_arvalid & s_axi_arready;
  assign status_word   = {23'h000000, car_up_r, standby_n,
                          ch2_stat.on, ch2_stat.chopped, ch2_stat.trip,
                          ch1_stat.on, ch1_stat.chopped, ch1_stat.trip};
  assign rd_mapped     = (s_axi_araddr[11:2] == REG_CTRL[11:2])   |
                         (s_axi_araddr[11:2] == REG_FSCALE[11:2]) |
                         (s_axi_araddr[11:2] == REG_PERIOD[11:2]) |
                         (s_axi_araddr[11:2] == REG_STATUS[11:2]);
  assign rd_mux = (s_axi_araddr[11:2] == REG_CTRL[11:2])   ? {31'h00000000, ctrl_en_r} :
                  (s_axi_araddr[11:2] == REG_FSCALE[11:2]) ? {24'h000000, fscale_r}    :
                  (s_axi_araddr[11:2] == REG_PERIOD[11:2]) ? {16'h0000, period_r}      :
                  (s_axi_araddr[11:2] == REG_STATUS[11:2]) ? status_word               :
                  32'h0000_0000;

  // Read data registered one cycle after the address is taken
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata  = rdata_r;
  assign s_axi_rresp  = rresp_r;

endmodule
`default_nettype wire

// >>> dv/stc_chk_sva.sv
// Checker on top ports: decode, off states, bus holds
// Assumes one clock; bound into stc_top
`timescale 1ns/1ps
`default_nettype none
module stc_chk_sva (
  // Clock, reset, standby, channel pins
  input wire logic        clk, reset_n, standby_n,
  input wire logic        ch1_dir_a_in, ch1_dir_b_in, ch1_level_sel_low, ch1_level_sel_high,
  input wire logic        ch1_bridge_a_out, ch1_bridge_b_out, ch1_bridge_a_en, ch1_bridge_b_en,
  input wire logic        ch2_dir_a_in, ch2_dir_b_in, ch2_bridge_a_en, ch2_bridge_b_en,
  // Bus
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_rvalid, s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic [31:0] s_axi_rdata
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_dir_fwd: assert property (
    ch1_dir_a_in && !ch1_dir_b_in && standby_n |=> ch1_bridge_a_out && !ch1_bridge_b_out)
    else $error("forward levels wrong");
  a_dir_rev: assert property (
    !ch1_dir_a_in && ch1_dir_b_in && standby_n |=> !ch1_bridge_a_out && ch1_bridge_b_out)
    else $error("reverse levels wrong");
  a_equal_off: assert property (
    ch1_dir_a_in == ch1_dir_b_in |=> !ch1_bridge_a_en && !ch1_bridge_b_en)
    else $error("ch1 on with equal phases");
  a_ch2_equal: assert property (
    ch2_dir_a_in == ch2_dir_b_in |=> !ch2_bridge_a_en && !ch2_bridge_b_en)
    else $error("ch2 on with equal phases");
  a_standby_off: assert property (!standby_n |=> !ch1_bridge_a_en && !ch2_bridge_a_en)
    else $error("on in standby");
  a_zero_level: assert property (
    ch1_level_sel_low && ch1_level_sel_high |=> !ch1_bridge_a_en)
    else $error("on at zero level");
  a_rise_delay: assert property ($rose(ch1_dir_a_in) |=> !ch1_bridge_a_en [*8])
    else $error("on during phase delay");
  a_en_pair: assert property (
    ch1_bridge_a_en == ch1_bridge_b_en && ch2_bridge_a_en == ch2_bridge_b_en)
    else $error("halves enabled apart");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
endmodule
bind stc_top stc_chk_sva u_chk (.*);
`default_nettype wire

// >>> dv/stc_step_model.sv
// Stepping controller model: one channel's pins
// Assumes commands change after a rising edge
`timescale 1ns/1ps
`default_nettype none
module stc_step_model (
  // Clock, reset, command {a, b, lo, hi}
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [3:0] cmd,
  // Pins
  output logic            dir_a,
  output logic            dir_b,
  output logic            sel_lo,
  output logic            sel_hi
);
  // ==========================================================================
  // Pins move only after an edge
  // ==========================================================================
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) {dir_a, dir_b, sel_lo, sel_hi} <= 4'h0;  // Idle, bridge off
    else {dir_a, dir_b, sel_lo, sel_hi} <= cmd;
  end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench: registers, decode, delay, chopping
// Assumes package constants; PERIOD set small for short runs
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import stc_pkg::*;
  // ==========================================================================
  // Signals
  // ==========================================================================
  logic clk = 0, reset_n = 0, standby_n = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, d1a, d1b, s1l, s1h, d2a, d2b, s2l, s2h;
  logic a1o, a1e, b1o, b1e, a2o, a2e, b2o, b2e, awr, wr, bv, arr, rv;
  logic [3:0] cmd1 = 0, cmd2 = 0;       // Partner commands
  logic [7:0] sense1 = 0, sense2 = 0;   // Sense codes
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd, rnd = 32'h90d7;
  logic [1:0] br, rr;
  int n_errors = 0, check_count = 0;
  always #5 clk = ~clk;
  stc_step_model M1 (.clk(clk), .reset_n(reset_n), .cmd(cmd1), .dir_a(d1a), .dir_b(d1b),
    .sel_lo(s1l), .sel_hi(s1h));
  stc_step_model M2 (.clk(clk), .reset_n(reset_n), .cmd(cmd2), .dir_a(d2a), .dir_b(d2b),
    .sel_lo(s2l), .sel_hi(s2h));
  stc_top DUT (.clk(clk), .reset_n(reset_n), .ch1_dir_a_in(d1a), .ch1_dir_b_in(d1b),
    .ch1_level_sel_low(s1l), .ch1_level_sel_high(s1h), .ch1_sense_voltage(sense1),
    .ch1_bridge_a_out(a1o), .ch1_bridge_a_en(a1e), .ch1_bridge_b_out(b1o), .ch1_bridge_b_en(b1e),
    .ch2_dir_a_in(d2a), .ch2_dir_b_in(d2b), .ch2_level_sel_low(s2l), .ch2_level_sel_high(s2h),
    .ch2_sense_voltage(sense2), .ch2_bridge_a_out(a2o), .ch2_bridge_a_en(a2e),
    .ch2_bridge_b_out(b2o), .ch2_bridge_b_en(b2e), .standby_n(standby_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wr), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rready));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13; v ^= v >> 17; return v ^ (v << 5);
  endfunction
  // Threshold per select index at reset scale
  function automatic logic [7:0] thr(input int s);
    return s == 0 ? FSCALE_RST : 8'((16'(FSCALE_RST) * (s == 1 ? FRAC_70 : FRAC_30)) >> 8);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end
  endtask
  // Sample on falling edges
  task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
  // Both halves offered, each dropped once taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh; logic [1:0] r; int n;
    @(posedge clk); awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1; n = 0;
    do begin
      @(negedge clk); ah = awvalid && awr; wh = wvalid && wr; bh = bv; r = br;
      @(posedge clk); if (ah) awvalid <= 0; if (wh) wvalid <= 0; n++;
    end while (!bh && n < 50);
    bready <= 0; chk(r, er);
  endtask
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ah, rh; logic [31:0] d; logic [1:0] r; int n;
    @(posedge clk); araddr <= a; arvalid <= 1; rready <= 1; n = 0;
    do begin
      @(negedge clk); ah = arvalid && arr; rh = rv; d = rd; r = rr;
      @(posedge clk); if (ah) arvalid <= 0; n++;
    end while (!rh && n < 50);
    rready <= 0; chk(d, ed); chk(r, er);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ==========================================================================
  // Watchdog and main
  // ==========================================================================
  initial begin #100000; n_errors++; report_and_stop; end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1;
    axi_rd(REG_CTRL, 32'(CTRL_RST), RESP_OKAY);
    axi_rd(REG_FSCALE, 32'(FSCALE_RST), RESP_OKAY);
    axi_rd(REG_PERIOD, 32'd3333, RESP_OKAY);
    axi_rd(12'h010, 32'h0, RESP_SLVERR);                 // Unmapped
    rnd = xs(rnd); axi_wr(REG_FSCALE, rnd, RESP_OKAY);
    axi_rd(REG_FSCALE, rnd & 32'hff, RESP_OKAY);
    axi_wr(REG_FSCALE, 32'(FSCALE_RST), RESP_OKAY);
    axi_wr(REG_PERIOD, 32'd100, RESP_OKAY);
    axi_rd(REG_PERIOD, 32'd100, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin                    // Decode, random ch2
      rnd = xs(rnd); @(posedge clk); cmd1 <= {i[1], i[0], 2'b00}; cmd2 <= {rnd[1:0], 2'b00};
      cyc(320); chk(a1e, i[1] ^ i[0]);
      if (i[1] ^ i[0]) chk({a1o, b1o}, {i[1], i[0]});
      chk(a2e, rnd[1] ^ rnd[0]);
      if (rnd[1] ^ rnd[0]) chk({a2o, b2o}, rnd[1:0]);
    end
    @(posedge clk); cmd1 <= 4'b0000; cyc(5); @(posedge clk); cmd1 <= 4'b1000;
    cyc(295); chk(a1e, 0);
    cyc(12); chk(a1e, 1);
    @(posedge clk); sense1 <= 8'hff; cyc(180); chk(a1e, 1);
    cyc(30); chk(a1e, 0);
    @(posedge clk); sense1 <= 0; cyc(120); chk(a1e, 1);
    for (int s = 0; s < 3; s++) begin                    // Exact thresholds
      @(posedge clk); cmd1 <= {2'b10, s == 1, s == 2}; cyc(210);
      @(posedge clk); sense1 <= thr(s); cyc(4); chk(a1e, 1);
      @(posedge clk); sense1 <= thr(s) + 8'h01; cyc(4); chk(a1e, 0);
      @(posedge clk); sense1 <= 0; cyc(120); chk(a1e, 1);
    end
    @(posedge clk); cmd1 <= 4'b1011; cyc(4); chk(a1e, 0);
    @(posedge clk); cmd1 <= 4'b1000; cyc(4); chk(a1e, 1);
    @(posedge clk); standby_n <= 0; cyc(3); chk({a1e, a2e}, 0);
    report_and_stop;
  end
endmodule
`default_nettype wire
